// [aac_consts.vh]
/*
  Constants of the audio amplifier control register bank: offsets, field
  positions, reset values and the two-wire bus slave address.
  Assumes it is included by the register bank module only.
*/
`ifndef AAC_CONSTS_VH
`define AAC_CONSTS_VH

// Register offsets
`define AAC_FAULT_AND_REVISION_STATUS 3'h0
`define AAC_AMPLIFIER_ENABLE_CONTROL 3'h1
`define AAC_ATTACK_AND_SPEAKER_LIMIT 3'h2
`define AAC_RELEASE_AND_HEADPHONE_LIMIT 3'h3
`define AAC_MUX_MODE_AND_MONO_VOLUME 3'h4
`define AAC_STEREO_ONE_VOLUME_AND_GAINS 3'h5
`define AAC_STEREO_TWO_VOLUME_AND_PHONE_ATTENUATION_CODE 3'h6

// Field positions
`define AAC_THERMAL_BIT 0
`define AAC_OVERCURRENT_BIT 1
`define AAC_LIMITER_LEVEL_SELECT_BIT 7
`define AAC_GAIN_LIMITER_ENABLE_BIT 6
`define AAC_SOFT_SHUTDOWN_BIT 4
`define AAC_LEFT_PHONE_ENABLE_BIT 3
`define AAC_RIGHT_PHONE_ENABLE_BIT 2
`define AAC_SPEAKER_ENABLE_BIT 1
`define AAC_VOICE_SPEAKER_BYPASS_BIT 0
`define AAC_SPEAKER_GAIN_BIT 7
`define AAC_PHONE_UNITY_GAIN_OVERRIDE_BIT 6

// Writable bit masks, reserved bits held at zero
`define AAC_AMP_CTL_MASK 8'hDF
`define AAC_STEREO_ONE_MASK 8'hDF

// Reset values
`define AAC_AMP_CTL_RESET 8'h81
`define AAC_ATTACK_RESET 8'h25
`define AAC_RELEASE_RESET 8'h57
`define AAC_MUX_MONO_RESET 8'h0D
`define AAC_STEREO_ONE_RESET 8'h0D
`define AAC_STEREO_TWO_RESET 8'h0D

// Headphone attenuation, 1.5 dB steps below 0 dB
`define AAC_PHONE_MAX_ATTEN_STEPS 4'h8

// Two-wire slave address, 7 bits
`define AAC_SLAVE_ADDRESS 7'h70

`endif

// [aac_register_bank.v]
/*
  Audio amplifier control register bank with its two-wire bus slave.
  Seven 8-bit registers at indices 0 to 6, sequential addressing.
  Assumes scl_in, sda_in and the fault inputs are asynchronous to
  core_clk_in and that SCL is slow enough to be sampled (4+ cycles per level).
  The bus wire level is resolved outside from sda_oe_out (drives low).
*/
// Behaviour
// - Register 0 top nibble: fixed read-only revision
// - Over-current event sets sticky fault bit 1
// - Any write to register 0 clears fault unless over-current is active
// - Thermal bit follows live thermal shutdown state
// - Register 1 bit 7 picks limiter level
// - Register 1 bit 6 enables gain limiter
// - Register 1 bit 4 soft shutdown all
// - Register 1 bits 3,2 enable headphone channels
// - Register 1 bit 1 enables speaker amplifier
// - Bypass forces speaker off, bypasses speaker volume
// - Register 2 attack code, reset 00100
// - Register 2 speaker limit level, reset 101
// - Register 3 release code, reset 01010
// - Register 3 headphone limit level, reset 111
// - Register 4 mux mode, reset 000
// - Register 4 mono volume, reset 01101
// - Register 5 pair one volume, reset 01101
// - Register 6 pair two volume, reset 01101
// - Register 5 bit 7 speaker 12/6 dB
// - Register 5 bit 6 forces headphone 0 dB
// - Headphone gain code maps in 1.5 dB steps
// - Sequential writes advance register index per byte
// - Bypass routes bypass pins to speaker outputs
`timescale 1ns/1ps
`include "aac_consts.vh"

module aac_register_bank #(
  parameter [3:0] REVISION = 4'h3 // Arbitrary value
) (
  // Clock and reset
  input wire core_clk_in,
  input wire rstn_in,
  // Two-wire bus pins
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_out,
  // Analog status
  input wire overcurrent_in,
  input wire thermal_shutdown_in,
  // Amplifier controls
  output reg soft_shutdown_out,
  output reg left_phone_on_out,
  output reg right_phone_on_out,
  output reg speaker_amp_on_out,
  output reg voice_speaker_bypass_out,
  output reg speaker_volume_bypass_out,
  output reg speaker_high_gain_out,
  output reg [3:0] phone_atten_steps_out,
  // Limiter controls
  output reg gain_limiter_enable_out,
  output reg [2:0] limiter_level_out,
  output reg [4:0] attack_time_code_out,
  output reg [4:0] release_time_code_out,
  // Mux and volumes
  output reg [2:0] mux_mode_out,
  output reg [4:0] mono_input_volume_out,
  output reg [4:0] pair_one_volume_out,
  output reg [4:0] pair_two_volume_out
);

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_ACK_ADDR = 4'h2;
  localparam [3:0] ST_INDEX = 4'h3;
  localparam [3:0] ST_ACK_INDEX = 4'h4;
  localparam [3:0] ST_WDATA = 4'h5;
  localparam [3:0] ST_ACK_WDATA = 4'h6;
  localparam [3:0] ST_RDATA = 4'h7;
  localparam [3:0] ST_RACK = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers and bus edge detection

  reg scl_m_q;
  reg scl_s_q;
  reg scl_d_q;
  reg sda_m_q;
  reg sda_s_q;
  reg sda_d_q;
  reg oc_m_q;
  reg oc_s_q;
  reg th_m_q;
  reg th_s_q;

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_d_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_d_q <= 1'b1;
      oc_m_q <= 1'b0;
      oc_s_q <= 1'b0;
      th_m_q <= 1'b0;
      th_s_q <= 1'b0;
    end else begin
      scl_m_q <= scl_in;
      scl_s_q <= scl_m_q;
      scl_d_q <= scl_s_q;
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
      sda_d_q <= sda_s_q;
      oc_m_q <= overcurrent_in;
      oc_s_q <= oc_m_q;
      th_m_q <= thermal_shutdown_in;
      th_s_q <= th_m_q;
    end
  end

  wire scl_rise = scl_s_q & ~scl_d_q;
  wire scl_fall = ~scl_s_q & scl_d_q;
  wire bus_start = scl_s_q & scl_d_q & sda_d_q & ~sda_s_q;
  wire bus_stop = scl_s_q & scl_d_q & ~sda_d_q & sda_s_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  reg fault_q;
  reg [7:0] amp_ctl_q;
  reg [7:0] attack_q;
  reg [7:0] release_q;
  reg [7:0] mux_mono_q;
  reg [7:0] stereo_one_q;
  reg [7:0] stereo_two_q;

  // Read view of one register, unmapped index reads zero
  function [7:0] reg_view;
    input [2:0] idx;
    input [55:0] image;
    begin
      case (idx)
        `AAC_FAULT_AND_REVISION_STATUS: reg_view = image[7:0];
        `AAC_AMPLIFIER_ENABLE_CONTROL: reg_view = image[15:8];
        `AAC_ATTACK_AND_SPEAKER_LIMIT: reg_view = image[23:16];
        `AAC_RELEASE_AND_HEADPHONE_LIMIT: reg_view = image[31:24];
        `AAC_MUX_MODE_AND_MONO_VOLUME: reg_view = image[39:32];
        `AAC_STEREO_ONE_VOLUME_AND_GAINS: reg_view = image[47:40];
        `AAC_STEREO_TWO_VOLUME_AND_PHONE_ATTENUATION_CODE: reg_view = image[55:48];
        default: reg_view = 8'h00;
      endcase
    end
  endfunction

  // All registers side by side, index 0 in the low byte
  wire [55:0] reg_image = {stereo_two_q, stereo_one_q, mux_mono_q, release_q, attack_q,
    amp_ctl_q, REVISION, 2'b00, fault_q, th_s_q};

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  reg [3:0] state_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg [2:0] index_q;
  reg read_q;
  reg master_ack_q;
  reg wr_en;
  reg [7:0] wr_data;
  wire [7:0] cur_view = reg_view(index_q, reg_image);
  wire [7:0] next_view = reg_view(index_q + 3'h1, reg_image);

  always @* begin
    wr_en = 1'b0;
    wr_data = shift_q;
    if (state_q == ST_WDATA && scl_fall && bit_cnt_q == 4'h8 && !bus_start && !bus_stop) begin
      wr_en = 1'b1;
    end
  end

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      index_q <= 3'h0;
      read_q <= 1'b0;
      master_ack_q <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (bus_start) begin
      // Start or repeated start ends any sequence
      state_q <= ST_ADDR;
      bit_cnt_q <= 4'h0;
      sda_oe_out <= 1'b0;
    end else if (bus_stop) begin
      state_q <= ST_IDLE;
      sda_oe_out <= 1'b0;
    end else begin
      case (state_q)
        ST_ADDR, ST_INDEX, ST_WDATA: begin
          if (scl_rise && bit_cnt_q != 4'h8) begin
            shift_q <= {shift_q[6:0], sda_s_q};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == 4'h8) begin
            bit_cnt_q <= 4'h0;
            if (state_q == ST_ADDR) begin
              if (shift_q[7:1] == `AAC_SLAVE_ADDRESS) begin
                read_q <= shift_q[0];
                sda_oe_out <= 1'b1;
                state_q <= ST_ACK_ADDR;
              end else begin
                state_q <= ST_IDLE;
              end
            end else if (state_q == ST_INDEX) begin
              index_q <= shift_q[2:0];
              sda_oe_out <= 1'b1;
              state_q <= ST_ACK_INDEX;
            end else begin
              index_q <= index_q + 3'h1;
              sda_oe_out <= 1'b1;
              state_q <= ST_ACK_WDATA;
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_INDEX, ST_ACK_WDATA: begin
          if (scl_fall) begin
            if (state_q == ST_ACK_ADDR && read_q) begin
              shift_q <= cur_view;
              sda_oe_out <= ~cur_view[7];
              state_q <= ST_RDATA;
            end else begin
              sda_oe_out <= 1'b0;
              state_q <= (state_q == ST_ACK_ADDR) ? ST_INDEX : ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_q == 4'h8) begin
              bit_cnt_q <= 4'h0;
              sda_oe_out <= 1'b0;
              state_q <= ST_RACK;
            end else begin
              shift_q <= {shift_q[6:0], 1'b0};
              sda_oe_out <= ~shift_q[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            master_ack_q <= ~sda_s_q;
          end else if (scl_fall) begin
            if (master_ack_q) begin
              shift_q <= next_view;
              sda_oe_out <= ~next_view[7];
              index_q <= index_q + 3'h1;
              state_q <= ST_RDATA;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_IDLE: begin
          sda_oe_out <= 1'b0;
        end
        default: begin
          state_q <= ST_IDLE;
          sda_oe_out <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and fault flag

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fault_q <= 1'b0;
      amp_ctl_q <= `AAC_AMP_CTL_RESET;
      attack_q <= `AAC_ATTACK_RESET;
      release_q <= `AAC_RELEASE_RESET;
      mux_mono_q <= `AAC_MUX_MONO_RESET;
      stereo_one_q <= `AAC_STEREO_ONE_RESET;
      stereo_two_q <= `AAC_STEREO_TWO_RESET;
    end else begin
      // Set wins over the clearing write
      if (oc_s_q) begin
        fault_q <= 1'b1;
      end else if (wr_en && index_q == `AAC_FAULT_AND_REVISION_STATUS) begin
        fault_q <= 1'b0;
      end
      if (wr_en) begin
        case (index_q)
          `AAC_AMPLIFIER_ENABLE_CONTROL: amp_ctl_q <= wr_data & `AAC_AMP_CTL_MASK;
          `AAC_ATTACK_AND_SPEAKER_LIMIT: attack_q <= wr_data;
          `AAC_RELEASE_AND_HEADPHONE_LIMIT: release_q <= wr_data;
          `AAC_MUX_MODE_AND_MONO_VOLUME: mux_mono_q <= wr_data;
          `AAC_STEREO_ONE_VOLUME_AND_GAINS: stereo_one_q <= wr_data & `AAC_STEREO_ONE_MASK;
          `AAC_STEREO_TWO_VOLUME_AND_PHONE_ATTENUATION_CODE: stereo_two_q <= wr_data;
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered control outputs

  wire sw_off = amp_ctl_q[`AAC_SOFT_SHUTDOWN_BIT];
  wire bypass = amp_ctl_q[`AAC_VOICE_SPEAKER_BYPASS_BIT];
  wire unity = stereo_one_q[`AAC_PHONE_UNITY_GAIN_OVERRIDE_BIT];

  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      soft_shutdown_out <= 1'b0;
      left_phone_on_out <= 1'b0;
      right_phone_on_out <= 1'b0;
      speaker_amp_on_out <= 1'b0;
      voice_speaker_bypass_out <= 1'b1;
      speaker_volume_bypass_out <= 1'b1;
      speaker_high_gain_out <= 1'b0;
      phone_atten_steps_out <= `AAC_PHONE_MAX_ATTEN_STEPS;
      gain_limiter_enable_out <= 1'b0;
      limiter_level_out <= 3'h5;
      attack_time_code_out <= 5'h04;
      release_time_code_out <= 5'h0A;
      mux_mode_out <= 3'h0;
      mono_input_volume_out <= 5'h0D;
      pair_one_volume_out <= 5'h0D;
      pair_two_volume_out <= 5'h0D;
    end else begin
      soft_shutdown_out <= sw_off;
      left_phone_on_out <= amp_ctl_q[`AAC_LEFT_PHONE_ENABLE_BIT] & ~sw_off;
      right_phone_on_out <= amp_ctl_q[`AAC_RIGHT_PHONE_ENABLE_BIT] & ~sw_off;
      speaker_amp_on_out <= amp_ctl_q[`AAC_SPEAKER_ENABLE_BIT] & ~bypass & ~sw_off;
      voice_speaker_bypass_out <= bypass;
      speaker_volume_bypass_out <= bypass;
      speaker_high_gain_out <= stereo_one_q[`AAC_SPEAKER_GAIN_BIT];
      phone_atten_steps_out <= unity ? 4'h0 :
        (`AAC_PHONE_MAX_ATTEN_STEPS - {1'b0, stereo_two_q[7:5]});
      gain_limiter_enable_out <= amp_ctl_q[`AAC_GAIN_LIMITER_ENABLE_BIT];
      limiter_level_out <= amp_ctl_q[`AAC_LIMITER_LEVEL_SELECT_BIT] ?
        attack_q[2:0] : release_q[2:0];
      attack_time_code_out <= attack_q[7:3];
      release_time_code_out <= release_q[7:3];
      mux_mode_out <= mux_mono_q[7:5];
      mono_input_volume_out <= mux_mono_q[4:0];
      pair_one_volume_out <= stereo_one_q[4:0];
      pair_two_volume_out <= stereo_two_q[4:0];
    end
  end

endmodule

// [aac_i2c_master.sv]
/*
  Two-wire bus master model that reaches the register bank.
  Assumes the bench resolves SDA from sda_low_out and the slave's enable,
  with a pull-up; SCL runs at 8 core clocks a bit, only within frames.
*/
`timescale 1ns/1ps

module aac_i2c_master (
  // Clock
  input wire logic clk_in,
  // Bus
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  logic [6:0] dev_addr = 7'h70;
  logic ack;

  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // SDA moves only while SCL is low, sampled late in the high phase
  task automatic bit_io(input logic v, output logic s);
    @(posedge clk_in) scl_out <= 1'b0;
    @(posedge clk_in) sda_low_out <= ~v;
    repeat (3) @(posedge clk_in);
    scl_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    s = sda_in;
  endtask

  // Start when stop is 0, stop when 1
  task automatic cond(input logic stop);
    @(posedge clk_in) scl_out <= 1'b0;
    @(posedge clk_in) sda_low_out <= stop;
    repeat (3) @(posedge clk_in);
    scl_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    sda_low_out <= ~stop;
    repeat (4) @(posedge clk_in);
  endtask

  // Eight bits MSB first, then the acknowledge bit
  task automatic byte_io(input logic [7:0] tx, input logic last, output logic [7:0] rx);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(last, s);
    ack = ~s;
  endtask

  // Ack reports the address acknowledge
  task automatic write_regs(input logic [7:0] idx, input logic [23:0] d, input int n);
    logic [7:0] r;
    logic ok;
    cond(1'b0);
    byte_io({dev_addr, 1'b0}, 1'b1, r);
    ok = ack;
    byte_io(idx, 1'b1, r);
    for (int k = 0; k < n; k++) byte_io(d[23 - 8 * k -: 8], 1'b1, r);
    cond(1'b1);
    ack = ok;
  endtask

  task automatic read_reg(input logic [7:0] idx, output logic [7:0] q);
    logic [7:0] r;
    cond(1'b0);
    byte_io({dev_addr, 1'b0}, 1'b1, r);
    byte_io(idx, 1'b1, r);
    cond(1'b0);
    byte_io({dev_addr, 1'b1}, 1'b1, r);
    byte_io(8'hFF, 1'b1, q);
    cond(1'b1);
  endtask

  // Two bytes from consecutive indices, acknowledge after the first
  task automatic read_pair(input logic [7:0] idx, output logic [15:0] q);
    logic [7:0] r;
    cond(1'b0);
    byte_io({dev_addr, 1'b0}, 1'b1, r);
    byte_io(idx, 1'b1, r);
    cond(1'b0);
    byte_io({dev_addr, 1'b1}, 1'b1, r);
    byte_io(8'hFF, 1'b0, q[15:8]);
    byte_io(8'hFF, 1'b1, q[7:0]);
    cond(1'b1);
  endtask
endmodule

// [aac_register_bank_sva.sv]
/*
  Checker of the register bank's port behaviour.
  Assumes it is bound to aac_register_bank and sees its ports only.
*/
`timescale 1ns/1ps

module aac_register_bank_sva (
  // Clock and reset
  input wire core_clk_in,
  input wire rstn_in,
  // Bus pins
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_out,
  // Controls
  input wire soft_shutdown_out,
  input wire left_phone_on_out,
  input wire right_phone_on_out,
  input wire speaker_amp_on_out,
  input wire voice_speaker_bypass_out,
  input wire speaker_volume_bypass_out,
  input wire [3:0] phone_atten_steps_out,
  input wire [2:0] mux_mode_out,
  input wire [4:0] attack_time_code_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);

  ////////////////////////////////////////////////////////////////////////
  sequence s_stop;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence

  sequence s_quiet;
    !sda_oe_out [*8];
  endsequence

  a_stop_frees_bus: assert property (s_stop |-> ##1 s_quiet)
    else $error("slave drives SDA after stop");
  a_drive_in_low: assert property ($rose(sda_oe_out) |-> !$past(scl_in))
    else $error("SDA pulled while SCL high");
  a_open_drain_low: assert property (sda_out == 1'b0)
    else $error("SDA data value not low");
  a_shutdown_gates_all: assert property (
    soft_shutdown_out |-> !(left_phone_on_out || right_phone_on_out || speaker_amp_on_out))
    else $error("amplifier on during shutdown");
  a_bypass_kills_spk: assert property (voice_speaker_bypass_out |-> !speaker_amp_on_out)
    else $error("speaker on in bypass");
  a_volume_bypass_same: assert property (
    speaker_volume_bypass_out == voice_speaker_bypass_out)
    else $error("volume bypass differs");
  a_atten_in_range: assert property (phone_atten_steps_out <= 4'h8)
    else $error("attenuation out of range");
  a_mode_at_byte: assert property ($changed(mux_mode_out) |-> !$past(scl_in, 2))
    else $error("mode changed outside byte end");
  a_attack_at_byte: assert property (
    $changed(attack_time_code_out) |-> !$past(scl_in, 2))
    else $error("attack changed outside byte end");
endmodule

bind aac_register_bank aac_register_bank_sva i_sva (
  .core_clk_in(core_clk_in), .rstn_in(rstn_in), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .soft_shutdown_out(soft_shutdown_out),
  .left_phone_on_out(left_phone_on_out), .right_phone_on_out(right_phone_on_out),
  .speaker_amp_on_out(speaker_amp_on_out), .voice_speaker_bypass_out(voice_speaker_bypass_out),
  .speaker_volume_bypass_out(speaker_volume_bypass_out),
  .phone_atten_steps_out(phone_atten_steps_out), .mux_mode_out(mux_mode_out),
  .attack_time_code_out(attack_time_code_out));

// [audio_amp_control_registers_bench.sv]
/*
  Self-checking bench of the register bank through the two-wire bus.
  Assumes the master model and the checker files are compiled first.
*/
`timescale 1ns/1ps

module audio_amp_control_registers_bench;
  localparam logic [3:0] REV = 4'h9; // Arbitrary revision value
  localparam logic [55:0] RST = {24'h0D0D0D, 24'h572581, REV, 4'h0};
  localparam logic [63:0] CTL = 64'h5E87_4E77_8B48_8630;

  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic oc = 1'b0;
  logic therm = 1'b0;
  logic scl, sda_low, sda_oe, sda_drv;
  logic soft_shutdown, lpo, rpo, spk, byp, vbyp, hig, gain_limiter_enable;
  logic [3:0] att;
  logic [2:0] lim, mode;
  logic [4:0] atk, rel, mono, p1, p2;
  logic [15:0] pair;
  int num_errors = 0;
  int samples_checked = 0;
  wire sda = ~(sda_low | sda_oe);

  aac_register_bank #(.REVISION(REV)) i_dut (
    .core_clk_in(core_clk), .rstn_in(rstn), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_drv), .sda_oe_out(sda_oe), .overcurrent_in(oc),
    .thermal_shutdown_in(therm), .soft_shutdown_out(soft_shutdown), .left_phone_on_out(lpo),
    .right_phone_on_out(rpo), .speaker_amp_on_out(spk), .voice_speaker_bypass_out(byp),
    .speaker_volume_bypass_out(vbyp), .speaker_high_gain_out(hig),
    .phone_atten_steps_out(att), .gain_limiter_enable_out(gain_limiter_enable), .limiter_level_out(lim),
    .attack_time_code_out(atk), .release_time_code_out(rel), .mux_mode_out(mode),
    .mono_input_volume_out(mono), .pair_one_volume_out(p1), .pair_two_volume_out(p2));

  aac_i2c_master i_mst (
    .clk_in(core_clk), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    i_mst.read_reg(idx, q);
    check(q, exp);
  endtask

  task automatic print_verdict();
    $display("Checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge core_clk);
    num_errors++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (5) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      rd_chk(8'(i), i < 7 ? RST[8 * i +: 8] : 8'h00);
    end
    check({lim, att, byp}, {3'h5, 4'h8, 1'b1});
    // Reserved bits written as zero
    i_mst.write_regs(8'h05, {8'hDF, 8'hB3, 8'h00}, 2);
    check({7'h0, i_mst.ack}, 8'h01);
    check({3'h0, p1}, 8'h1F);
    check({3'h0, p2}, 8'h13);
    check({3'h0, hig, att}, 8'h10);
    rd_chk(8'h06, 8'hB3);
    i_mst.write_regs(8'h05, {8'h1F, 16'h0}, 1);
    check({3'h0, hig, att}, 8'h03);
    // Extremes of the limiter fields, mute first
    i_mst.write_regs(8'h02, {8'hF8, 8'h03, 8'hFF}, 3);
    check({3'h0, atk}, 8'h1F);
    check({3'h0, rel}, 8'h00);
    check({mode, mono}, 8'hFF);
    check({5'h0, lim}, 8'h00);
    i_mst.write_regs(8'h04, {8'h6D, 16'h0}, 1);
    check({mode, mono}, 8'h6D);
    // Sequential read with master acknowledge
    i_mst.read_pair(8'h02, pair);
    check(pair[15:8], 8'hF8);
    check(pair[7:0], 8'h03);
    for (int i = 0; i < 4; i++) begin
      i_mst.write_regs(8'h01, {CTL[63 - 16 * i -: 8], 16'h0}, 1);
      check({soft_shutdown, lpo, rpo, spk, byp, gain_limiter_enable, lim[1:0]}, CTL[55 - 16 * i -: 8]);
      check({7'h0, vbyp}, {7'h0, CTL[56 - 16 * i]});
    end
    rd_chk(8'h01, 8'h86);
    // Sticky fault, cleared by a write
    @(posedge core_clk) oc <= 1'b1;
    repeat (4) @(posedge core_clk);
    oc <= 1'b0;
    rd_chk(8'h00, {REV, 4'h2});
    rd_chk(8'h00, {REV, 4'h2});
    i_mst.write_regs(8'h00, {8'hFF, 16'h0}, 1);
    rd_chk(8'h00, {REV, 4'h0});
    @(posedge core_clk) therm <= 1'b1;
    i_mst.write_regs(8'h00, {8'h00, 16'h0}, 1);
    rd_chk(8'h00, {REV, 4'h1});
    @(posedge core_clk) therm <= 1'b0;
    rd_chk(8'h00, {REV, 4'h0});
    // Index wraps from the unmapped index to register 0
    i_mst.read_pair(8'h07, pair);
    check(pair[15:8], 8'h00);
    check(pair[7:0], {REV, 4'h0});
    // Unmapped index and foreign address
    i_mst.write_regs(8'h07, {8'h55, 16'h0}, 1);
    rd_chk(8'h07, 8'h00);
    i_mst.dev_addr = 7'h71;
    i_mst.write_regs(8'h01, {8'h00, 16'h0}, 1);
    check({7'h0, i_mst.ack}, 8'h00);
    i_mst.dev_addr = 7'h70;
    rd_chk(8'h01, 8'h86);
    // Second reset in mid-run
    @(posedge core_clk) rstn <= 1'b0;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (5) @(posedge core_clk);
    rd_chk(8'h01, 8'h81);
    print_verdict();
  end
endmodule
